// >>> src/timer_pkg.sv
`default_nettype none
package timer_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_BLOCKS = 4;
	localparam int NUM_HALVES = 8;
	localparam int ADDR_W = 8;
	localparam int CTL_W = 8;
	localparam int STAT_W = 6;

	// ----------------------------------------------------------------
	// register word index within a block (byte address = block * 0x40 + 4 * index)
	// ----------------------------------------------------------------
	localparam logic [3:0] IDX_CFG = 4'h0;
	localparam logic [3:0] IDX_CTL_A = 4'h1;
	localparam logic [3:0] IDX_CTL_B = 4'h2;
	localparam logic [3:0] IDX_LOAD_A = 4'h3;
	localparam logic [3:0] IDX_LOAD_B = 4'h4;
	localparam logic [3:0] IDX_MATCH_A = 4'h5;
	localparam logic [3:0] IDX_MATCH_B = 4'h6;
	localparam logic [3:0] IDX_PRE_A = 4'h7;
	localparam logic [3:0] IDX_PRE_B = 4'h8;
	localparam logic [3:0] IDX_VALUE_A = 4'h9;
	localparam logic [3:0] IDX_VALUE_B = 4'ha;
	localparam logic [3:0] IDX_CAPT_A = 4'hb;
	localparam logic [3:0] IDX_CAPT_B = 4'hc;
	localparam logic [3:0] IDX_STATUS = 4'hd;
	localparam logic [3:0] IDX_INT_EN = 4'he;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CFG_JOIN_BIT = 0;
	localparam int CFG_MODE_LSB = 1;
	localparam int CTL_EN_BIT = 0;
	localparam int CTL_MODE_LSB = 1;
	localparam int CTL_INV_BIT = 4;
	localparam int CTL_ADC_BIT = 5;
	localparam int CTL_FALL_BIT = 6;
	localparam int CTL_CNT_BIT = 7;
	localparam int ST_TIMEOUT = 0;
	localparam int ST_CAPTURE = 1;
	localparam int ST_MATCH = 2;
	localparam int ST_PER_HALF = 3;

	// ----------------------------------------------------------------
	// mode codes
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_ONESHOT = 3'h0;
	localparam logic [2:0] MODE_PERIODIC = 3'h1;
	localparam logic [2:0] MODE_CAPTURE = 3'h2;
	localparam logic [2:0] MODE_PWM = 3'h3;
	localparam logic [2:0] MODE_RTC = 3'h4;
	localparam logic [1:0] JOIN_ONESHOT = 2'h0;
	localparam logic [1:0] JOIN_PERIODIC = 2'h1;
	localparam logic [1:0] JOIN_RTC = 2'h2;

	// ----------------------------------------------------------------
	// reset values and bus answers
	// ----------------------------------------------------------------
	localparam logic [31:0] LOAD_RST = 32'h0000ffff;
	localparam logic [31:0] MATCH_RST = 32'h00000000;
	localparam logic [7:0] PRE_RST = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : timer_pkg
`default_nettype wire

// >>> src/timer_half_unit.sv
`default_nettype none
module timer_half_unit (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, high
	input wire logic en, // half enabled
	input wire logic [2:0] mode, // mode code
	input wire logic wide, // 32-bit joined operation
	input wire logic invert, // pwm inversion
	input wire logic count_edges, // tick on pin edges
	input wire logic use_fall, // falling edge selected
	input wire logic [7:0] pre, // prescale value
	input wire logic [31:0] load, // interval
	input wire logic [31:0] match, // match value
	input wire logic pin_rise, // filtered rising edge
	input wire logic pin_fall, // filtered falling edge
	output logic [31:0] value, // counter
	output logic [31:0] capt, // captured count
	output logic timeout, // timeout pulse
	output logic capture, // capture pulse
	output logic match_hit, // match pulse
	output logic pwm // waveform
);
	import timer_pkg::*;

	logic run_reg, run_next;
	logic en_d_reg;
	logic [31:0] cnt_reg, cnt_next;
	logic [7:0] pre_reg, pre_next;
	logic [31:0] capt_reg, capt_next;
	logic to_reg, to_next, cap_reg, cap_next, mt_reg, mt_next, pwm_reg, pwm_next;
	logic [31:0] top, loadm;
	logic edge_sel, tick;

	always_comb begin
		top = wide ? 32'hffffffff : 32'h0000ffff;
		loadm = load & top;
		edge_sel = use_fall ? pin_fall : pin_rise;
		run_next = run_reg;
		cnt_next = cnt_reg;
		pre_next = pre_reg;
		capt_next = capt_reg;
		to_next = 1'b0;
		cap_next = 1'b0;
		mt_next = 1'b0;
		tick = 1'b0;
		if (run_reg && (!count_edges || edge_sel)) begin
			if (pre_reg == 8'h00) begin
				tick = 1'b1;
				pre_next = pre;
			end else begin
				pre_next = pre_reg - 8'h01;
			end
		end
		if (!en) begin
			run_next = 1'b0;
		end else if (!en_d_reg) begin
			run_next = 1'b1;
			cnt_next = loadm;
			pre_next = pre;
		end else if (tick) begin
			if (mode == MODE_RTC) begin
				cnt_next = cnt_reg + 32'h00000001;
				mt_next = (cnt_next == match);
			end else if (cnt_reg == 32'h00000000) begin
				to_next = 1'b1;
				if (mode == MODE_ONESHOT) begin
					run_next = 1'b0;
				end else begin
					cnt_next = loadm;
				end
			end else begin
				cnt_next = cnt_reg - 32'h00000001;
				mt_next = (mode == MODE_PWM) && (cnt_next == (match & top));
			end
		end
		if (run_reg && mode == MODE_CAPTURE && edge_sel) begin
			capt_next = cnt_reg;
			cap_next = 1'b1;
		end
		pwm_next = (mode == MODE_PWM && run_reg) ? ((cnt_reg > (match & top)) ^ invert) : invert;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			run_reg <= 1'b0;
			en_d_reg <= 1'b0;
			cnt_reg <= 32'h00000000;
			pre_reg <= 8'h00;
			capt_reg <= 32'h00000000;
			to_reg <= 1'b0;
			cap_reg <= 1'b0;
			mt_reg <= 1'b0;
			pwm_reg <= 1'b0;
		end else begin
			run_reg <= run_next;
			en_d_reg <= en;
			cnt_reg <= cnt_next;
			pre_reg <= pre_next;
			capt_reg <= capt_next;
			to_reg <= to_next;
			cap_reg <= cap_next;
			mt_reg <= mt_next;
			pwm_reg <= pwm_next;
		end
	end

	assign value = cnt_reg;
	assign capt = capt_reg;
	assign timeout = to_reg;
	assign capture = cap_reg;
	assign match_hit = mt_reg;
	assign pwm = pwm_reg;

endmodule : timer_half_unit
`default_nettype wire

// >>> src/general_purpose_timer_module.sv
// Notes on behaviour
// - four independent identical timer blocks
// - two 16-bit halves, timer or counter
// - halves join into 32-bit timer/clock
// - joined modes: clock, one-shot, periodic
// - 16-bit one-shot/periodic with 8-bit prescaler
// - 16-bit half captures or makes pwm
// - count or time external pin events
// - trigger output starts converter on timeout
// - pwm output inversion selectable by software
`default_nettype none
module general_purpose_timer_module (
	input wire logic REF_CLK, // system clock
	input wire logic RST, // synchronous reset, high
	input wire logic [timer_pkg::ADDR_W-1:0] AWADDR, // write address
	input wire logic AWVALID, // write address valid
	output logic AWREADY, // write address ready
	input wire logic [31:0] WDATA, // write data
	input wire logic [3:0] WSTRB, // byte enables
	input wire logic WVALID, // write data valid
	output logic WREADY, // write data ready
	output logic [1:0] BRESP, // write response
	output logic BVALID, // write response valid
	input wire logic BREADY, // write response ready
	input wire logic [timer_pkg::ADDR_W-1:0] ARADDR, // read address
	input wire logic ARVALID, // read address valid
	output logic ARREADY, // read address ready
	output logic [31:0] RDATA, // read data
	output logic [1:0] RRESP, // read response
	output logic RVALID, // read data valid
	input wire logic RREADY, // read data ready
	input wire logic [timer_pkg::NUM_HALVES-1:0] CAPTURE_COMPARE_PWM_PIN_IN, // pin level in
	output logic [timer_pkg::NUM_HALVES-1:0] CAPTURE_COMPARE_PWM_PIN_OUT, // pin drive
	output logic [timer_pkg::NUM_HALVES-1:0] CAPTURE_COMPARE_PWM_PIN_OE, // pin drive enable
	output logic [timer_pkg::NUM_BLOCKS-1:0] ADC_TRIG, // converter start pulse
	output logic [timer_pkg::NUM_BLOCKS-1:0] IRQ // interrupt request level
);
	import timer_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [2:0] cfg_reg [NUM_BLOCKS];
	logic [2:0] cfg_next [NUM_BLOCKS];
	logic [STAT_W-1:0] inten_reg [NUM_BLOCKS];
	logic [STAT_W-1:0] inten_next [NUM_BLOCKS];
	logic [CTL_W-1:0] ctl_reg [NUM_HALVES];
	logic [CTL_W-1:0] ctl_next [NUM_HALVES];
	logic [31:0] load_reg [NUM_HALVES];
	logic [31:0] load_next [NUM_HALVES];
	logic [31:0] match_reg [NUM_HALVES];
	logic [31:0] match_next [NUM_HALVES];
	logic [7:0] pre_reg [NUM_HALVES];
	logic [7:0] pre_next [NUM_HALVES];
	logic [NUM_HALVES*ST_PER_HALF-1:0] status_reg, status_next;
	logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
	logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic awready_reg, wready_reg, arready_reg, bvalid_reg, rvalid_reg;
	logic bvalid_next, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [NUM_HALVES-1:0] s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;
	logic [NUM_HALVES-1:0] rise, fall, ev_to, ev_cap, ev_mt, pwm_w, oe_next;
	logic [NUM_HALVES-1:0] pin_out_reg, pin_oe_reg;
	logic [NUM_BLOCKS-1:0] adc_reg, adc_next, irq_reg, irq_next;
	logic [31:0] value_w [NUM_HALVES];
	logic [31:0] capt_w [NUM_HALVES];
	logic [2:0] mode_w [NUM_HALVES];
	logic [NUM_HALVES-1:0] en_w, wide_w;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = data[8*i +: 8];
			end
		end
		return r;
	endfunction : merge

	// ----------------------------------------------------------------
	// pin filter: a change counts once stages two and three agree
	// ----------------------------------------------------------------
	always_comb begin
		lvl_next = (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
		rise = lvl_next & ~lvl_reg;
		fall = ~lvl_next & lvl_reg;
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			lvl_reg <= '0;
		end else begin
			s1_reg <= CAPTURE_COMPARE_PWM_PIN_IN;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			lvl_reg <= lvl_next;
		end
	end

	// ----------------------------------------------------------------
	// timer halves
	// ----------------------------------------------------------------
	// blocks share nothing but the bus
	generate
		for (genvar h = 0; h < NUM_HALVES; h++) begin : g_half
			localparam int B = h / 2;
			always_comb begin
				// half A widens, half B is idle while joined
				wide_w[h] = cfg_reg[B][CFG_JOIN_BIT] && (h % 2 == 0);
				en_w[h] = ctl_reg[h][CTL_EN_BIT] && !(cfg_reg[B][CFG_JOIN_BIT] && (h % 2 == 1));
				if (wide_w[h]) begin
					case (cfg_reg[B][CFG_MODE_LSB +: 2])
						JOIN_PERIODIC: mode_w[h] = MODE_PERIODIC;
						JOIN_RTC: mode_w[h] = MODE_RTC;
						default: mode_w[h] = MODE_ONESHOT;
					endcase
				end else begin
					mode_w[h] = {1'b0, ctl_reg[h][CTL_MODE_LSB +: 2]};
				end
				oe_next[h] = en_w[h] && mode_w[h] == MODE_PWM;
			end
			timer_half_unit u_half (
				.clk(REF_CLK),
				.rst(RST),
				.en(en_w[h]),
				.mode(mode_w[h]),
				.wide(wide_w[h]),
				.invert(ctl_reg[h][CTL_INV_BIT]),
				.count_edges(ctl_reg[h][CTL_CNT_BIT]),
				.use_fall(ctl_reg[h][CTL_FALL_BIT]),
				.pre(pre_reg[h]),
				.load(load_reg[h]),
				.match(match_reg[h]),
				.pin_rise(rise[h]),
				.pin_fall(fall[h]),
				.value(value_w[h]),
				.capt(capt_w[h]),
				.timeout(ev_to[h]),
				.capture(ev_cap[h]),
				.match_hit(ev_mt[h]),
				.pwm(pwm_w[h])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// register bus and flags
	// ----------------------------------------------------------------
	logic wr_fire;
	logic [1:0] wblk, rblk;
	logic [3:0] widx, ridx;
	logic [2:0] ha, hb;
	logic [31:0] rw;

	always_comb begin
		cfg_next = cfg_reg;
		inten_next = inten_reg;
		ctl_next = ctl_reg;
		load_next = load_reg;
		match_next = match_reg;
		pre_next = pre_reg;
		status_next = status_reg;
		aw_full_next = aw_full_reg;
		aw_addr_next = aw_addr_reg;
		w_full_next = w_full_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (AWVALID && awready_reg) begin
			aw_full_next = 1'b1;
			aw_addr_next = AWADDR;
		end
		if (WVALID && wready_reg) begin
			w_full_next = 1'b1;
			wdata_next = WDATA;
			wstrb_next = WSTRB;
		end
		if (bvalid_reg && BREADY) bvalid_next = 1'b0;
		wblk = aw_addr_reg[7:6];
		widx = aw_addr_reg[5:2];
		ha = {wblk, 1'b0};
		hb = {wblk, 1'b1};
		wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
		if (wr_fire) begin
			aw_full_next = 1'b0;
			w_full_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = RESP_OKAY;
			case (widx)
				IDX_CFG: cfg_next[wblk] = 3'(merge({29'h0, cfg_reg[wblk]}, wdata_reg, wstrb_reg));
				IDX_CTL_A: ctl_next[ha] = CTL_W'(merge({24'h0, ctl_reg[ha]}, wdata_reg, wstrb_reg));
				IDX_CTL_B: ctl_next[hb] = CTL_W'(merge({24'h0, ctl_reg[hb]}, wdata_reg, wstrb_reg));
				IDX_LOAD_A: load_next[ha] = merge(load_reg[ha], wdata_reg, wstrb_reg);
				IDX_LOAD_B: load_next[hb] = merge(load_reg[hb], wdata_reg, wstrb_reg);
				IDX_MATCH_A: match_next[ha] = merge(match_reg[ha], wdata_reg, wstrb_reg);
				IDX_MATCH_B: match_next[hb] = merge(match_reg[hb], wdata_reg, wstrb_reg);
				IDX_PRE_A: pre_next[ha] = 8'(merge({24'h0, pre_reg[ha]}, wdata_reg, wstrb_reg));
				IDX_PRE_B: pre_next[hb] = 8'(merge({24'h0, pre_reg[hb]}, wdata_reg, wstrb_reg));
				IDX_STATUS: begin
					if (wstrb_reg[0]) begin
						status_next[wblk*STAT_W +: STAT_W] = status_reg[wblk*STAT_W +: STAT_W] & ~wdata_reg[STAT_W-1:0];
					end
				end
				IDX_INT_EN: inten_next[wblk] = STAT_W'(merge({26'h0, inten_reg[wblk]}, wdata_reg, wstrb_reg));
				// value and capture words take writes silently; only unmapped words refuse
				default: bresp_next = (widx > IDX_INT_EN) ? RESP_SLVERR : RESP_OKAY;
			endcase
		end
		// hardware set wins over a same-cycle clear
		for (int h = 0; h < NUM_HALVES; h++) begin
			if (ev_to[h]) status_next[h*ST_PER_HALF + ST_TIMEOUT] = 1'b1;
			if (ev_cap[h]) status_next[h*ST_PER_HALF + ST_CAPTURE] = 1'b1;
			if (ev_mt[h]) status_next[h*ST_PER_HALF + ST_MATCH] = 1'b1;
		end
		if (rvalid_reg && RREADY) rvalid_next = 1'b0;
		rblk = ARADDR[7:6];
		ridx = ARADDR[5:2];
		case (ridx)
			IDX_CFG: rw = {29'h0, cfg_reg[rblk]};
			IDX_CTL_A: rw = {24'h0, ctl_reg[{rblk, 1'b0}]};
			IDX_CTL_B: rw = {24'h0, ctl_reg[{rblk, 1'b1}]};
			IDX_LOAD_A: rw = load_reg[{rblk, 1'b0}];
			IDX_LOAD_B: rw = load_reg[{rblk, 1'b1}];
			IDX_MATCH_A: rw = match_reg[{rblk, 1'b0}];
			IDX_MATCH_B: rw = match_reg[{rblk, 1'b1}];
			IDX_PRE_A: rw = {24'h0, pre_reg[{rblk, 1'b0}]};
			IDX_PRE_B: rw = {24'h0, pre_reg[{rblk, 1'b1}]};
			IDX_VALUE_A: rw = value_w[{rblk, 1'b0}];
			IDX_VALUE_B: rw = value_w[{rblk, 1'b1}];
			IDX_CAPT_A: rw = capt_w[{rblk, 1'b0}];
			IDX_CAPT_B: rw = capt_w[{rblk, 1'b1}];
			IDX_STATUS: rw = {26'h0, status_reg[rblk*STAT_W +: STAT_W]};
			IDX_INT_EN: rw = {26'h0, inten_reg[rblk]};
			default: rw = 32'h00000000;
		endcase
		if (ARVALID && arready_reg) begin
			rvalid_next = 1'b1;
			rdata_next = rw;
			rresp_next = (ridx > IDX_INT_EN) ? RESP_SLVERR : RESP_OKAY;
		end
		for (int b = 0; b < NUM_BLOCKS; b++) begin
			adc_next[b] = (ev_to[2*b] && ctl_reg[2*b][CTL_ADC_BIT]) || (ev_to[2*b+1] && ctl_reg[2*b+1][CTL_ADC_BIT]);
			irq_next[b] = |(status_reg[b*STAT_W +: STAT_W] & inten_reg[b]);
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			for (int b = 0; b < NUM_BLOCKS; b++) begin
				cfg_reg[b] <= 3'h0;
				inten_reg[b] <= '0;
			end
			for (int h = 0; h < NUM_HALVES; h++) begin
				ctl_reg[h] <= '0;
				load_reg[h] <= LOAD_RST;
				match_reg[h] <= MATCH_RST;
				pre_reg[h] <= PRE_RST;
			end
			status_reg <= '0;
			aw_full_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_full_reg <= 1'b0;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			arready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= 32'h00000000;
			pin_out_reg <= '0;
			pin_oe_reg <= '0;
			adc_reg <= '0;
			irq_reg <= '0;
		end else begin
			cfg_reg <= cfg_next;
			inten_reg <= inten_next;
			ctl_reg <= ctl_next;
			load_reg <= load_next;
			match_reg <= match_next;
			pre_reg <= pre_next;
			status_reg <= status_next;
			aw_full_reg <= aw_full_next;
			aw_addr_reg <= aw_addr_next;
			w_full_reg <= w_full_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			// ready is registered from the next holding flag, so it changes on the same edge as the flag
			awready_reg <= !aw_full_next;
			wready_reg <= !w_full_next;
			arready_reg <= !rvalid_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			// pin driven only in pwm mode
			pin_out_reg <= pwm_w;
			pin_oe_reg <= oe_next;
			adc_reg <= adc_next;
			irq_reg <= irq_next;
		end
	end

	assign AWREADY = awready_reg;
	assign WREADY = wready_reg;
	assign BVALID = bvalid_reg;
	assign BRESP = bresp_reg;
	assign ARREADY = arready_reg;
	assign RVALID = rvalid_reg;
	assign RRESP = rresp_reg;
	assign RDATA = rdata_reg;
	assign CAPTURE_COMPARE_PWM_PIN_OUT = pin_out_reg;
	assign CAPTURE_COMPARE_PWM_PIN_OE = pin_oe_reg;
	assign ADC_TRIG = adc_reg;
	assign IRQ = irq_reg;

endmodule : general_purpose_timer_module
`default_nettype wire

// >>> verification/timer_checker_assertions.sv
`default_nettype none
module timer_checker
	import timer_pkg::*;
(
	input wire logic REF_CLK, // clock
	input wire logic RST, // reset
	input wire logic AWVALID, // aw valid
	input wire logic AWREADY, // aw ready
	input wire logic WVALID, // w valid
	input wire logic WREADY, // w ready
	input wire logic [1:0] BRESP, // b resp
	input wire logic BVALID, // b valid
	input wire logic BREADY, // b ready
	input wire logic ARVALID, // ar valid
	input wire logic ARREADY, // ar ready
	input wire logic [31:0] RDATA, // r data
	input wire logic [1:0] RRESP, // r resp
	input wire logic RVALID, // r valid
	input wire logic RREADY, // r ready
	input wire logic [timer_pkg::NUM_HALVES-1:0] CAPTURE_COMPARE_PWM_PIN_OE, // pin enable
	input wire logic [timer_pkg::NUM_BLOCKS-1:0] ADC_TRIG, // trigger
	input wire logic [timer_pkg::NUM_BLOCKS-1:0] IRQ // interrupt
);
	// ----------------------------------------------------------------
	// bus and reset relations
	// ----------------------------------------------------------------
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	AST_B_AFTER_AW_W: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
		else $error("write response missing");
	AST_B_HOLD: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response dropped early");
	AST_B_DONE: assert property (BVALID && BREADY |=> !BVALID)
		else $error("write response repeated");
	AST_R_AFTER_AR: assert property (ARVALID && ARREADY |=> RVALID)
		else $error("read data late");
	AST_R_HOLD: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
		else $error("read data changed while waiting");
	AST_AR_BLOCKED: assert property (RVALID |-> !ARREADY)
		else $error("second read accepted");
	AST_ERR_ZERO: assert property (RVALID && RRESP == RESP_SLVERR |-> RDATA == 32'h0)
		else $error("refused read carries data");
	AST_READY_UP: assert property (!RST && $past(RST) |=> AWREADY && WREADY && ARREADY)
		else $error("ready not raised after reset");
	// outputs must be quiet in reset, so reset is not a disable here
	AST_RESET_QUIET: assert property (@(posedge REF_CLK) disable iff (1'b0)
		RST |=> !BVALID && !RVALID && ADC_TRIG == 4'h0 && IRQ == 4'h0 && CAPTURE_COMPARE_PWM_PIN_OE == 8'h00)
		else $error("outputs active in reset");
endmodule : timer_checker
`default_nettype wire

// >>> verification/pin_model.sv
`default_nettype none
module pin_model (
	input wire logic clk, // clock
	input wire logic [7:0] pulse, // start a pin pulse
	input wire logic [7:0] drv, // design pin drive
	input wire logic [7:0] oe, // design drive enable
	output logic [7:0] pin // resolved pin level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] lvl = 8'h00;
	logic [3:0] remain [8] = '{default: 4'h0};
	// ----------------------------------------------------------------
	// external event source
	// ----------------------------------------------------------------
	// pulse held eight clocks
	always @(posedge clk) begin
		for (int i = 0; i < 8; i++) begin
			if (pulse[i])
				remain[i] <= 4'h8;
			else if (remain[i] != 4'h0)
				remain[i] <= remain[i] - 4'h1;
			lvl[i] <= pulse[i] || remain[i] > 4'h1;
		end
	end
	// design owns the wire while enabled
	assign pin = (oe & drv) | (~oe & lvl);
endmodule : pin_model
`default_nettype wire

// >>> verification/general_purpose_timer_module_bench.sv
`default_nettype none
module general_purpose_timer_module_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import timer_pkg::*;
	logic REF_CLK = 1'b0;
	logic RST = 1'b1;
	logic [7:0] AWADDR = 8'h00;
	logic AWVALID = 1'b0;
	logic [31:0] WDATA = 32'h0;
	logic [3:0] WSTRB = 4'hf;
	logic WVALID = 1'b0;
	logic BREADY = 1'b0;
	logic [7:0] ARADDR = 8'h00;
	logic ARVALID = 1'b0;
	logic RREADY = 1'b0;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [1:0] BRESP, RRESP;
	logic [31:0] RDATA;
	logic [7:0] CAPTURE_COMPARE_PWM_PIN_IN, CAPTURE_COMPARE_PWM_PIN_OUT, CAPTURE_COMPARE_PWM_PIN_OE;
	logic [3:0] ADC_TRIG, IRQ;
	logic [7:0] pulse = 8'h00;
	int n_errors = 0;
	int compares = 0;
	always #12.5 REF_CLK = ~REF_CLK;
	general_purpose_timer_module dut (.*);
	pin_model model (.clk(REF_CLK), .pulse(pulse), .drv(CAPTURE_COMPARE_PWM_PIN_OUT),
		.oe(CAPTURE_COMPARE_PWM_PIN_OE), .pin(CAPTURE_COMPARE_PWM_PIN_IN));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic finish_test;
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test
	task automatic tmo;
		n_errors++;
		$display("MISMATCH %0t wait ran out", $time);
		finish_test();
	endtask : tmo
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	function automatic logic [7:0] ad(input logic [1:0] b, input logic [3:0] i);
		return {b, i, 2'h0};
	endfunction : ad
	// ready raised only after valid is seen, so slow-master holds get exercised
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge REF_CLK);
			if (BVALID && BREADY) break;
			if (BVALID) BREADY <= 1'b1;
			if (AWREADY) AWVALID <= 1'b0;
			if (WREADY) WVALID <= 1'b0;
		end
		r = BRESP;
		BREADY <= 1'b0;
		if (n == 64) tmo();
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		ARADDR <= a;
		ARVALID <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge REF_CLK);
			if (RVALID && RREADY) break;
			if (RVALID) RREADY <= 1'b1;
			if (ARREADY) ARVALID <= 1'b0;
		end
		d = RDATA;
		r = RRESP;
		RREADY <= 1'b0;
		if (n == 64) tmo();
	endtask : rd
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
	endtask : w
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
	endtask : rc
	task automatic wait_adc(input int b, output int n);
		for (n = 1; n <= 200; n++) begin
			@(posedge REF_CLK);
			if (ADC_TRIG[b] === 1'b1) break;
		end
		if (n > 200) tmo();
	endtask : wait_adc
	// counts high cycles of a pwm pin (sel 1) or a trigger line (sel 0)
	task automatic count_hi(input int sel, input int i, input int len, output int h);
		h = 0;
		repeat (len) begin
			@(posedge REF_CLK);
			if ((sel ? CAPTURE_COMPARE_PWM_PIN_OUT[i] : ADC_TRIG[i]) === 1'b1) h++;
		end
	endtask : count_hi
	task automatic pls(input int i);
		pulse[i] <= 1'b1;
		@(posedge REF_CLK);
		pulse[i] <= 1'b0;
		repeat (20) @(posedge REF_CLK);
	endtask : pls
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int n;
		repeat (8) @(posedge REF_CLK);
		RST <= 1'b0;
		@(posedge REF_CLK);
		for (int b = 0; b < 4; b++) begin
			rc(ad(b, IDX_LOAD_A), LOAD_RST);
			rc(ad(b, IDX_MATCH_B), MATCH_RST);
			rc(ad(b, IDX_PRE_B), 32'h0);
			rc(ad(b, IDX_CTL_A), 32'h0);
			rc(ad(b, IDX_STATUS), 32'h0);
		end
		rd(ad(0, 4'hf), d, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		chk(d, 32'h0);
		wr(ad(0, 4'hf), 32'h1, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		WSTRB <= 4'h1;
		w(ad(0, IDX_MATCH_A), 32'h12345678);
		WSTRB <= 4'hf;
		rc(ad(0, IDX_MATCH_A), 32'h00000078);
		$display("test map done");
		w(ad(0, IDX_LOAD_A), 32'h5);
		w(ad(0, IDX_INT_EN), 32'h1);
		w(ad(0, IDX_CTL_A), 32'h21);
		wait_adc(0, n);
		count_hi(0, 0, 100, n);
		chk(n, 0);
		rc(ad(0, IDX_STATUS), 32'h1);
		chk({31'h0, IRQ[0]}, 32'h1);
		w(ad(0, IDX_STATUS), 32'h1);
		rc(ad(0, IDX_STATUS), 32'h0);
		repeat (2) @(posedge REF_CLK);
		chk({31'h0, IRQ[0]}, 32'h0);
		w(ad(0, IDX_CTL_A), 32'h0);
		w(ad(0, IDX_LOAD_A), 32'h3);
		w(ad(0, IDX_CFG), 32'h3);
		w(ad(0, IDX_CTL_A), 32'h21);
		wait_adc(0, n);
		wait_adc(0, n);
		chk(n, 4);
		w(ad(0, IDX_CTL_A), 32'h0);
		$display("test one_shot done");
		w(ad(1, IDX_PRE_A), 32'h3);
		w(ad(1, IDX_LOAD_A), 32'h4);
		w(ad(1, IDX_CTL_A), 32'h23);
		wait_adc(1, n);
		wait_adc(1, n);
		chk(n, 20);
		w(ad(1, IDX_CTL_A), 32'h0);
		w(ad(1, IDX_STATUS), 32'h3f);
		$display("test periodic done");
		w(ad(2, IDX_LOAD_A), 32'h0000fffe);
		w(ad(2, IDX_MATCH_A), 32'h00010001);
		w(ad(2, IDX_CFG), 32'h5);
		w(ad(2, IDX_CTL_A), 32'h1);
		repeat (10) @(posedge REF_CLK);
		rc(ad(2, IDX_STATUS), 32'h4);
		rc(ad(2, IDX_MATCH_A), 32'h00010001);
		rd(ad(2, IDX_VALUE_A), d, r);
		chk({31'h0, d > 32'h00010001}, 32'h1);
		$display("test joined done");
		w(ad(3, IDX_LOAD_A), 32'h9);
		w(ad(3, IDX_MATCH_A), 32'h2);
		w(ad(3, IDX_CTL_A), 32'h7);
		count_hi(1, 6, 20, n);
		chk(n, 14);
		chk({31'h0, CAPTURE_COMPARE_PWM_PIN_OE[6]}, 32'h1);
		w(ad(3, IDX_CTL_A), 32'h17);
		count_hi(1, 6, 20, n);
		chk(n, 6);
		w(ad(3, IDX_CTL_A), 32'h0);
		w(ad(3, IDX_STATUS), 32'h3f);
		$display("test pwm done");
		w(ad(3, IDX_LOAD_B), 32'hffff);
		w(ad(3, IDX_INT_EN), 32'h10);
		w(ad(3, IDX_CTL_B), 32'h5);
		pls(7);
		chk({31'h0, IRQ[3]}, 32'h1);
		rc(ad(3, IDX_STATUS), 32'h10);
		rd(ad(3, IDX_CAPT_B), d, r);
		chk({31'h0, d != 32'h0 && d <= 32'hffff}, 32'h1);
		w(ad(1, IDX_LOAD_B), 32'h1);
		w(ad(1, IDX_CTL_B), 32'h81);
		pls(3);
		rc(ad(1, IDX_STATUS), 32'h0);
		pls(3);
		rc(ad(1, IDX_STATUS), 32'h8);
		$display("test events done");
		RST <= 1'b1;
		repeat (8) @(posedge REF_CLK);
		RST <= 1'b0;
		@(posedge REF_CLK);
		rc(ad(1, IDX_LOAD_B), LOAD_RST);
		rc(ad(1, IDX_STATUS), 32'h0);
		$display("test reset done");
		finish_test();
	end
endmodule : general_purpose_timer_module_bench
bind general_purpose_timer_module timer_checker checker_i (.*);
`default_nettype wire
